// ### include/aesf_pkg.sv
`default_nettype none
package aesf_pkg;
   // Clocking and timing
   localparam int REF_CLK_MHZ = 100;
   localparam int BIT_TIME_US = 1;
   localparam int US_CYCLES = REF_CLK_MHZ * BIT_TIME_US;
   localparam int PERIOD_UNIT_US = 625;
   localparam int CERT_SPACING_US = 625;
   localparam int SPACING_BASE_OCTETS = 8;
   localparam int SPACING_GUARD_US = 30;
   localparam int MAX_RAND_DELAY_US = 10000;
   localparam int PERIOD_MIN_UNITS = 32;
   // Packet layout in octets
   localparam int PREAMBLE_OCTETS = 1;
   localparam int ACCESS_OCTETS = 4;
   localparam int HEADER_OCTETS = 2;
   localparam int ADDR_OCTETS = 6;
   localparam int MAX_DATA_OCTETS = 31;
   localparam int CRC_OCTETS = 3;
   localparam int PDU_START = PREAMBLE_OCTETS + ACCESS_OCTETS;
   localparam int ADDR_START = PDU_START + HEADER_OCTETS;
   localparam int DATA_START = ADDR_START + ADDR_OCTETS;
   // Link layer constants
   localparam logic [31:0] ADV_ACCESS_ADDR = 32'h8e89bed6;
   localparam logic [7:0] PREAMBLE_BYTE = 8'haa;
   localparam logic [23:0] CRC_INIT = 24'h555555;
   localparam logic [23:0] CRC_POLY = 24'h00065b;
   localparam logic [15:0] RAND_SEED = 16'hace1;
   // Channels, lowest frequency first
   localparam logic [5:0] CHAN_INDEX [3] = '{6'd37, 6'd38, 6'd39};
   localparam logic [11:0] CHAN_MHZ [3] = '{12'd2402, 12'd2426, 12'd2480};
   // Host port rates
   localparam int BAUD_LOW = 9600;
   localparam int BAUD_HIGH = 115200;
   localparam logic [13:0] BAUD_DIV_LOW = 14'(REF_CLK_MHZ * 1000000 / BAUD_LOW);
   localparam logic [13:0] BAUD_DIV_HIGH = 14'(REF_CLK_MHZ * 1000000 / BAUD_HIGH);
   typedef enum logic [1:0] {AESF_IDLE, AESF_BURST, AESF_WAIT} aesf_state_e;
endpackage
`default_nettype wire

// ### hw/aesf_core.sv
`default_nettype none
module aesf_core
   import aesf_pkg::*;
#(
   parameter int US_DIV = aesf_pkg::US_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic transmit_trigger_pin,
   input wire logic start_write,
   input wire logic stop_write,
   input wire logic cert_test_mode,
   input wire logic [14:0] event_period,
   input wire logic [2:0] event_count_limit,
   input wire logic [7:0] header_flags,
   input wire logic [5:0] adv_data_length,
   input wire logic [47:0] advertiser_address,
   input wire logic [247:0] advertising_payload,
   input wire logic host_port_select_pin,
   input wire logic rate_select_pin,
   input wire logic port_enable_addr_pin,
   output logic tx_bit,
   output logic tx_bit_valid,
   output logic [11:0] channel_freq_mhz,
   output logic tx_active,
   output logic event_start,
   output logic uart_port_sel,
   output logic [13:0] uart_baud_div,
   output logic uart_port_enable,
   output logic [1:0] i2c_addr_bits
);
   import aesf_pkg::*;

   // Octet of the unwhitened packet at a given position
   function automatic logic [7:0] octet_at(input logic [5:0] idx, input logic [7:0] hdr0, input logic [7:0] hdr1,
                                           input logic [47:0] addr, input logic [247:0] data);
      logic [7:0] res;
      res = 8'h00;
      if (idx < 6'(PREAMBLE_OCTETS))
         res = PREAMBLE_BYTE;
      else if (idx < 6'(PDU_START))
         res = ADV_ACCESS_ADDR[8*(idx-6'(PREAMBLE_OCTETS)) +: 8];
      else if (idx == 6'(PDU_START))
         res = hdr0;
      else if (idx < 6'(ADDR_START))
         res = hdr1;
      else if (idx < 6'(DATA_START))
         res = addr[8*(idx-6'(ADDR_START)) +: 8];
      else if (idx < 6'(DATA_START + MAX_DATA_OCTETS))
         res = data[8*(idx-6'(DATA_START)) +: 8];
      return res;
   endfunction

   aesf_state_e state;
   logic [6:0] us_div;
   logic us_tick;
   logic [9:0] chan_us;
   logic [23:0] evt_us;
   logic [8:0] bit_idx;
   logic bits_done;
   logic [1:0] chan;
   logic [2:0] events_done;
   logic trig_armed;
   logic [23:0] crc;
   logic [6:0] white;
   logic [15:0] rand_lfsr;
   logic [23:0] evt_target;
   logic strap_taken;
   logic strap_uart;
   logic strap_rate;

   logic [5:0] data_len;
   logic [5:0] payload_length_field;
   logic [9:0] spacing_us;
   logic [8:0] total_bits;
   logic [5:0] cur_octet;
   logic raw_bit;
   logic [7:0] cur_byte;
   logic burst_go;
   logic in_pdu;
   logic in_crc;
   logic data_bit;
   logic start_req;
   logic limit_hit;
   logic [23:0] period_us;

   // Data length clamped to the largest the payload can hold
   assign data_len = (adv_data_length > 6'(MAX_DATA_OCTETS)) ? 6'(MAX_DATA_OCTETS) : adv_data_length;
   assign payload_length_field = 6'(ADDR_OCTETS) + data_len;
   assign spacing_us = cert_test_mode ? 10'(CERT_SPACING_US) :
                       10'((10'(SPACING_BASE_OCTETS) + 10'(payload_length_field)) * 10'd8
                           + 10'(SPACING_GUARD_US));
   assign total_bits = 9'((DATA_START + CRC_OCTETS) * 8) + {data_len, 3'b000};
   assign cur_octet = bit_idx[8:3];
   assign cur_byte = octet_at(cur_octet, header_flags, {2'b00, payload_length_field},
                              advertiser_address, advertising_payload);
   assign raw_bit = cur_byte[bit_idx[2:0]];
   // Packet armed on the same tick the sequencer opens a channel slot, so spacing counts exactly
   assign burst_go = (state == AESF_IDLE && start_req)
                     || (state == AESF_WAIT && !stop_write && evt_us >= evt_target - 24'd1)
                     || (state == AESF_BURST && chan_us == spacing_us - 10'd1 && chan != 2'd2);
   assign in_pdu = (cur_octet >= 6'(PDU_START)) && (cur_octet < 6'(DATA_START) + data_len);
   assign in_crc = cur_octet >= 6'(DATA_START) + data_len;
   assign data_bit = in_crc ? crc[23] : raw_bit;
   // Period below the documented floor is raised to it, never shortened further
   assign period_us = 24'((event_period < 15'(PERIOD_MIN_UNITS) ? 15'(PERIOD_MIN_UNITS) : event_period)
                          * 24'(PERIOD_UNIT_US));
   assign start_req = start_write || (transmit_trigger_pin && trig_armed);
   assign limit_hit = (event_count_limit != 3'd0) && (events_done + 3'd1 == event_count_limit);
   assign us_tick = us_div == 7'(US_DIV - 1);
   assign tx_active = state != AESF_IDLE;

   // Microsecond base from the reference clock
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         us_div <= 7'd0;
      else
         us_div <= us_tick ? 7'd0 : us_div + 7'd1;
   end

   // Free-running random source for the event delay
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         rand_lfsr <= RAND_SEED;
      else
         rand_lfsr <= {rand_lfsr[14:0], rand_lfsr[15] ^ rand_lfsr[13] ^ rand_lfsr[12] ^ rand_lfsr[10]};
   end

   // Trigger re-arms only once the pin has been seen low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         trig_armed <= 1'b1;
      else if (!transmit_trigger_pin)
         trig_armed <= 1'b1;
      else if (state == AESF_IDLE && transmit_trigger_pin && trig_armed && us_tick)
         trig_armed <= 1'b0;
   end

   // Event sequencer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= AESF_IDLE;
         chan <= 2'd0;
         chan_us <= 10'd0;
         evt_us <= 24'd0;
         events_done <= 3'd0;
         evt_target <= 24'd0;
         event_start <= 1'b0;
      end else begin
         event_start <= 1'b0;
         case (state)
            AESF_IDLE: begin
               if (start_req && us_tick) begin
                  state <= AESF_BURST;
                  chan <= 2'd0;
                  chan_us <= 10'd0;
                  evt_us <= 24'd0;
                  events_done <= 3'd0;
                  // 13-bit draw keeps the delay inside 10 ms
                  evt_target <= period_us + 24'(rand_lfsr[12:0]);
                  event_start <= 1'b1;
               end
            end
            AESF_BURST: begin
               if (us_tick) begin
                  evt_us <= evt_us + 24'd1;
                  chan_us <= chan_us + 10'd1;
                  if (chan_us == spacing_us - 10'd1) begin
                     chan_us <= 10'd0;
                     if (chan != 2'd2)
                        chan <= chan + 2'd1;
                     else if (limit_hit || stop_write)
                        state <= AESF_IDLE;
                     else
                        state <= AESF_WAIT;
                  end
               end
               if (us_tick && chan == 2'd2 && chan_us == spacing_us - 10'd1)
                  events_done <= events_done + 3'd1;
            end
            AESF_WAIT: begin
               if (stop_write)
                  state <= AESF_IDLE;
               else if (us_tick) begin
                  evt_us <= evt_us + 24'd1;
                  // Next event counted from the start of the last one
                  if (evt_us >= evt_target - 24'd1) begin
                     state <= AESF_BURST;
                     chan <= 2'd0;
                     chan_us <= 10'd0;
                     evt_us <= 24'd0;
                     evt_target <= period_us + 24'(rand_lfsr[12:0]);
                     event_start <= 1'b1;
                  end
               end
            end
            default: state <= AESF_IDLE;
         endcase
      end
   end

   // Bit serializer, one bit per microsecond tick
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bit_idx <= 9'd0;
         bits_done <= 1'b1;
         tx_bit <= 1'b0;
         tx_bit_valid <= 1'b0;
      end else if (us_tick) begin
         if (state == AESF_BURST && !bits_done) begin
            tx_bit <= (in_pdu || in_crc) ? data_bit ^ white[6] : data_bit;
            tx_bit_valid <= 1'b1;
            bit_idx <= bit_idx + 9'd1;
            bits_done <= bit_idx == total_bits - 9'd1;
         end else begin
            bit_idx <= 9'd0;
            bits_done <= !burst_go;
            tx_bit_valid <= 1'b0;
            tx_bit <= 1'b0;
         end
      end
   end

   // CRC and whitening registers, reloaded at each packet start
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         crc <= CRC_INIT;
         white <= 7'h01;
      end else if (us_tick) begin
         if (bit_idx == 9'd0 && !(state == AESF_BURST && !bits_done && bit_idx != 9'd0)) begin
            crc <= CRC_INIT;
            white <= {CHAN_INDEX[chan][0], CHAN_INDEX[chan][1], CHAN_INDEX[chan][2],
                      CHAN_INDEX[chan][3], CHAN_INDEX[chan][4], CHAN_INDEX[chan][5], 1'b1};
         end
         if (state == AESF_BURST && !bits_done) begin
            if (in_pdu)
               crc <= {crc[22:0], 1'b0} ^ ((raw_bit ^ crc[23]) ? CRC_POLY : 24'h000000);
            else if (in_crc)
               crc <= {crc[22:0], 1'b0};
            if (in_pdu || in_crc)
               white <= {white[5], white[4], white[3] ^ white[6], white[2], white[1], white[0], white[6]};
         end
      end
   end

   // Carrier frequency for the radio
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         channel_freq_mhz <= CHAN_MHZ[0];
      else
         channel_freq_mhz <= CHAN_MHZ[chan];
   end

   // Straps caught once, on the first edge after reset release
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strap_taken <= 1'b0;
         strap_uart <= 1'b0;
         strap_rate <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         strap_uart <= host_port_select_pin;
         strap_rate <= rate_select_pin;
      end
   end

   // Host port configuration; enable pin stays live so the host can reset the port
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         uart_port_sel <= 1'b0;
         uart_baud_div <= BAUD_DIV_LOW;
         uart_port_enable <= 1'b0;
         i2c_addr_bits <= 2'b00;
      end else begin
         uart_port_sel <= strap_uart;
         uart_baud_div <= strap_rate ? BAUD_DIV_HIGH : BAUD_DIV_LOW;
         uart_port_enable <= strap_uart && port_enable_addr_pin;
         i2c_addr_bits <= strap_uart ? 2'b00 : {port_enable_addr_pin, strap_rate};
      end
   end
endmodule
`default_nettype wire

// ### tb/aesf_host_model.sv
`default_nettype none
module aesf_host_model #(
   parameter int US_DIV = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic want_tx,
   input wire logic [2:0] strap_in,
   output var logic trigger,
   output logic host_sel,
   output logic rate_sel,
   output logic enable_sel
);
   int low_cnt;
   // Straps follow the bench, which only changes them inside reset
   assign {host_sel, rate_sel, enable_sel} = strap_in;
   // Trigger rises only after a long enough low spell, so restarts are legal
   always_ff @(negedge ref_clk or posedge rst) begin
      if (rst) begin
         trigger <= 1'b0;
         low_cnt <= 0;
      end else if (!want_tx) begin
         trigger <= 1'b0;
         low_cnt <= (low_cnt < 1000) ? low_cnt + 1 : low_cnt;
      end else if (!trigger) begin
         if (low_cnt >= 10 * US_DIV) begin
            trigger <= 1'b1;
            low_cnt <= 0;
         end else
            low_cnt <= low_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// ### tb/aesf_core_properties.sv
`default_nettype none
module aesf_core_checker #(
   parameter int US_DIV = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cert_test_mode,
   input wire logic [5:0] adv_data_length,
   input wire logic host_port_select_pin,
   input wire logic rate_select_pin,
   input wire logic port_enable_addr_pin,
   input wire logic tx_bit,
   input wire logic tx_bit_valid,
   input wire logic [11:0] channel_freq_mhz,
   input wire logic tx_active,
   input wire logic event_start,
   input wire logic uart_port_sel,
   input wire logic [13:0] uart_baud_div,
   input wire logic uart_port_enable,
   input wire logic [1:0] i2c_addr_bits
);
   localparam int START_MAX = 2 * US_DIV;
   int vcnt;
   int gap;
   int len;
   logic pv;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   assign len = (adv_data_length > 6'd31) ? 31 : int'(adv_data_length);
   // Cycles inside a packet, and cycles since the last packet start in this event
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         vcnt <= 0;
         gap <= 1000000;
         pv <= 1'b0;
      end else begin
         pv <= tx_bit_valid;
         vcnt <= tx_bit_valid ? vcnt + 1 : 0;
         gap <= event_start ? 1000000 : (tx_bit_valid && !pv) ? 1 : (gap < 1000000) ? gap + 1 : gap;
      end
   end
   a_freq_legal: assert property (channel_freq_mhz inside {12'd2402, 12'd2426, 12'd2480})
      else $error("channel off the allowed set");
   a_freq_ascend: assert property ($changed(channel_freq_mhz) |-> channel_freq_mhz == 12'd2402
      || ($past(channel_freq_mhz) == 12'd2402 && channel_freq_mhz == 12'd2426)
      || ($past(channel_freq_mhz) == 12'd2426 && channel_freq_mhz == 12'd2480)) else $error("channel order");
   a_packet_len: assert property ($fell(tx_bit_valid) |-> vcnt == (16 + len) * 8 * US_DIV)
      else $error("packet length");
   a_bit_hold: assert property (tx_bit_valid && pv && $changed(tx_bit) |-> vcnt % US_DIV == 0)
      else $error("bit changed mid symbol");
   a_chan_spacing: assert property (tx_bit_valid && !pv && gap < 3000 * US_DIV
      |-> gap == (cert_test_mode ? 625 : (14 + len) * 8 + 30) * US_DIV) else $error("channel spacing");
   a_start_lat: assert property (event_start |-> ##[1:START_MAX] (tx_bit_valid && !pv && tx_active))
      else $error("no packet after event start");
   a_port_sel: assert property (!$past(rst) && !$past(rst, 2) |-> uart_port_sel == host_port_select_pin
      && uart_port_enable == (host_port_select_pin && port_enable_addr_pin)) else $error("port select");
   a_baud_div: assert property (!$past(rst) && !$past(rst, 2) && uart_port_sel
      |-> uart_baud_div == (rate_select_pin ? 14'd868 : 14'd10416)) else $error("baud divider");
   a_i2c_bits: assert property (!$past(rst) && !$past(rst, 2) |-> i2c_addr_bits ==
      (host_port_select_pin ? 2'b00 : {port_enable_addr_pin, rate_select_pin})) else $error("address bits");
endmodule
bind aesf_core aesf_core_checker #(.US_DIV(US_DIV)) aesf_core_checker_inst (.ref_clk(ref_clk), .rst(rst),
   .cert_test_mode(cert_test_mode), .adv_data_length(adv_data_length),
   .host_port_select_pin(host_port_select_pin), .rate_select_pin(rate_select_pin),
   .port_enable_addr_pin(port_enable_addr_pin), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
   .channel_freq_mhz(channel_freq_mhz), .tx_active(tx_active), .event_start(event_start),
   .uart_port_sel(uart_port_sel), .uart_baud_div(uart_baud_div), .uart_port_enable(uart_port_enable),
   .i2c_addr_bits(i2c_addr_bits));
`default_nettype wire

// ### tb/aesf_core_tb_top.sv
`default_nettype none
module aesf_core_tb_top;
   import aesf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int US = 4;
   logic ref_clk = 0, rst = 1, want_tx = 0, start_write = 0, stop_write = 0, cert_test_mode = 0;
   logic [14:0] event_period = 15'd32;
   logic [2:0] event_count_limit = 3'h0, straps = 3'h0;
   logic [7:0] header_flags = 8'h00;
   logic [5:0] adv_data_length = 6'h00;
   logic [47:0] advertiser_address = 48'h0;
   logic [247:0] advertising_payload = 248'h0;
   logic trig, hsel, rsel, epin, tx_bit, tx_bit_valid, tx_active, event_start, uart_port_sel, uart_port_enable;
   logic [11:0] channel_freq_mhz;
   logic [13:0] uart_baud_div;
   logic [1:0] i2c_addr_bits;
   int bad_count = 0, checked = 0, cyc = 0;
   always #5 ref_clk = ~ref_clk;
   aesf_host_model #(.US_DIV(US)) aesf_host_model_inst (.ref_clk(ref_clk), .rst(rst), .want_tx(want_tx),
      .strap_in(straps), .trigger(trig), .host_sel(hsel), .rate_sel(rsel), .enable_sel(epin));
   aesf_core #(.US_DIV(US)) aesf_core_inst (.ref_clk(ref_clk), .rst(rst), .transmit_trigger_pin(trig),
      .start_write(start_write), .stop_write(stop_write), .cert_test_mode(cert_test_mode),
      .event_period(event_period), .event_count_limit(event_count_limit), .header_flags(header_flags),
      .adv_data_length(adv_data_length), .advertiser_address(advertiser_address),
      .advertising_payload(advertising_payload), .host_port_select_pin(hsel), .rate_select_pin(rsel),
      .port_enable_addr_pin(epin), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
      .channel_freq_mhz(channel_freq_mhz), .tx_active(tx_active), .event_start(event_start),
      .uart_port_sel(uart_port_sel), .uart_baud_div(uart_baud_div), .uart_port_enable(uart_port_enable),
      .i2c_addr_bits(i2c_addr_bits));
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic conclude();
      $display("counts: %0d compared, %0d mismatched", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Preamble then access address, both unwhitened and sent low bit first
   function automatic logic exp_bit(input int k);
      return (k < 8) ? PREAMBLE_BYTE[k] : ADV_ACCESS_ADDR[k - 8];
   endfunction
   // Hang guard well above the longest event sequence
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         $display("mismatch at %0t: timeout", $time);
         conclude();
      end
   end
   // One event: start, three packets, then the stop behaviour
   task automatic run_event(input int len, input logic cert, input logic [2:0] lim, input logic by_pin);
      int n;
      @(negedge ref_clk);
      adv_data_length = 6'(len);
      cert_test_mode = cert;
      event_count_limit = lim;
      advertiser_address = {$urandom, $urandom};
      advertising_payload = 248'({8{$urandom}});
      header_flags = 8'($urandom);
      if (by_pin) want_tx = 1'b1;
      else start_write = 1'b1;
      n = 0;
      while (event_start !== 1'b1 && n < 2000) begin @(posedge ref_clk); #1; n++; end
      chk(n < 2000, "no event start");
      @(negedge ref_clk);
      start_write = 1'b0;
      for (int p = 0; p < 3; p++) begin
         n = 0;
         while (tx_bit_valid !== 1'b1 && n < 20000) begin @(posedge ref_clk); #1; n++; end
         chk(channel_freq_mhz === CHAN_MHZ[p], "channel");
         repeat (US / 2) @(posedge ref_clk);
         for (int k = 0; k < 40; k++) begin
            #1 chk(tx_bit === exp_bit(k), "frame bit");
            repeat (US) @(posedge ref_clk);
         end
         n = 0;
         while (tx_bit_valid === 1'b1 && n < 3000) begin @(posedge ref_clk); #1; n++; end
      end
      // Longer than any channel gap, so a limit stop must have landed
      repeat (700 * US) @(posedge ref_clk);
      #1 chk(tx_active === (lim != 3'd1), "active after event");
      @(negedge ref_clk);
      want_tx = 1'b0;
      stop_write = 1'b1;
      repeat (2 * US) @(negedge ref_clk);
      stop_write = 1'b0;
      chk(tx_active === 1'b0, "stop while waiting");
      $display("test done: len %0d cert %0d limit %0d pin %0d", len, cert, lim, by_pin);
   endtask
   initial begin
      void'($urandom(32'hae95));
      // Straps only change inside reset; both port modes get a pass
      for (int i = 0; i < 2; i++) begin
         @(negedge ref_clk);
         rst = 1'b1;
         straps = {1'(i), 2'($urandom)};
         repeat (3) @(negedge ref_clk);
         rst = 1'b0;
         repeat (3) @(negedge ref_clk);
         chk(uart_port_sel === straps[2] && uart_port_enable === (straps[2] & straps[0]), "port");
         chk(i2c_addr_bits === (straps[2] ? 2'b00 : {straps[0], straps[1]}), "address bits");
         if (straps[2]) chk(uart_baud_div === 14'(REF_CLK_MHZ * 1000000 / (straps[1] ? BAUD_HIGH : BAUD_LOW)), "baud");
         $display("test done: straps %b", straps);
      end
      run_event(int'($urandom_range(31, 0)), 1'b0, 3'd1, 1'b1);
      run_event(31, 1'b1, 3'd0, 1'b1);
      run_event(0, 1'b0, 3'($urandom_range(7, 2)), 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
